// File: rtl/t1c_pkg.sv
// Constants for the sixteen-bit timer/counter with prescaler
//
// Functional notes
// R01 - Enable bit 0 lets the counter advance; cleared freezes it.
// R02 - Three modes: timer, synchronous counter, asynchronous counter.
// R03 - Source select bit 1 clear: count each instruction cycle, core clock over four.
// R04 - Source select set: count rising edges of pin or timer oscillator.
// R05 - Bit 2 set bypasses synchronisation of external input; ignored in timer mode.
// R06 - Prescale field bits 5-4 divides selected input by 1, 2, 4 or 8.
// R07 - Bit 3 runs the low-power oscillator; clear shuts inverter and feedback off.
// R08 - Read-only bit 6 shows device clock taken from timer oscillator; resets 0.
// R09 - While enabled, both oscillator pins forced to inputs and read as zero.
// R10 - Bit 7 selects buffered 16-bit access; clear gives two direct byte accesses.
// R11 - Wide mode: high address is a buffer, low read copies live high byte.
// R12 - Wide mode: low write loads high byte from buffer at once.
// R13 - Wide mode: live high byte reached only through the buffer.
// R14 - High-byte writes keep prescaler count; low-byte writes clear it.
// R15 - Writable control bits and status bit reset to zero.
// R16 - Counter runs 0000h to FFFFh, wraps, latches overflow flag, gated by enable.
// R17 - Compare trigger clears counter in timer or sync mode; a write wins.
// R18 - Prescale codes 00, 01, 10, 11 give divide by 1, 2, 4, 8.
// R19 - Asynchronous counter keeps counting external edges during sleep.
package t1c_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  CNT_LO_OFS   = 8'h04;
  localparam logic [7:0]  CNT_HI_OFS   = 8'h08;
  localparam logic [7:0]  INT_STAT_OFS = 8'h0C;
  localparam logic [7:0]  INT_MASK_OFS = 8'h10;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int          BIT_ON       = 0;
  localparam int          BIT_CS       = 1;
  localparam int          BIT_SYNC     = 2;
  localparam int          BIT_OSC      = 3;
  localparam int          BIT_DIV_LO   = 4;
  localparam int          BIT_DIV_HI   = 5;
  localparam int          BIT_RUN      = 6;
  localparam int          BIT_WIDE     = 7;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK = 8'hBF;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [2:0]  PRE_RST      = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          CORE_HZ      = 100000000;
  localparam int          INSTR_DIV    = 4;
  localparam logic [1:0]  INSTR_LAST   = 2'(INSTR_DIV - 1);

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    MODE_TIMER = 3'b001,
    MODE_SYNC  = 3'b010,
    MODE_ASYNC = 3'b100
  } t1c_mode_e;

endpackage

// File: rtl/t1c_timer.sv
// Sixteen-bit timer/counter with prescaler, APB registers and overflow interrupt
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module t1c_timer
  import t1c_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Pins and system
  input  wire logic        i_ext_count_pin,
  input  wire logic        i_osc_input_pin,
  input  wire logic        i_sleep,
  input  wire logic        i_sysclk_from_timer_osc,
  input  wire logic        i_special_event,
  // Pin control and interrupt
  output logic             o_osc_run,
  output logic      [1:0]  o_pin_force_input,
  output logic             o_port_read_zero,
  output logic             o_irq
);
  import t1c_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]  ctrl;
  logic        sysclk_from_timer_osc;
  logic [15:0] count;
  logic [7:0]  hi_buf;
  logic [2:0]  pre_cnt;
  logic [1:0]  instr_cnt;
  logic        instr_tick;
  logic        ext_s1;
  logic        ext_s2;
  logic        osc_s1;
  logic        osc_s2;
  logic        sel_d;
  logic        sel_lvl;
  logic        ext_edge;
  logic        ext_pend;
  logic        src_tick;
  logic        cnt_inc;
  logic        trig_eff;
  logic        ovf_set;
  logic        overflow_flag;
  logic        ovf_mask;
  logic        mapped;
  logic        acc;
  logic        wr;
  logic        wr_ctrl;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_stat;
  logic        wr_mask;
  logic        rd_lo;
  logic        wide;
  logic [2:0]  div_mask;
  t1c_mode_e   mode;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
    at = (a == ofs);
  endfunction

  function automatic logic [2:0] divider_mask(input logic [1:0] sel);
    logic [2:0] m;
    m = 3'h0;
    unique case (sel)
      2'b00: m = 3'h0;
      2'b01: m = 3'h1;
      2'b10: m = 3'h3;
      2'b11: m = 3'h7;
    endcase
    divider_mask = m;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign mapped  = at(i_paddr, CTRL_OFS) | at(i_paddr, CNT_LO_OFS) | at(i_paddr, CNT_HI_OFS)
                 | at(i_paddr, INT_STAT_OFS) | at(i_paddr, INT_MASK_OFS);
  assign acc     = i_psel & i_penable & o_pready;
  assign wr      = acc & i_pwrite & mapped;
  assign wr_ctrl = wr & at(i_paddr, CTRL_OFS);
  assign wr_lo   = wr & at(i_paddr, CNT_LO_OFS);
  assign wr_hi   = wr & at(i_paddr, CNT_HI_OFS);
  assign wr_stat = wr & at(i_paddr, INT_STAT_OFS);
  assign wr_mask = wr & at(i_paddr, INT_MASK_OFS);
  assign rd_lo   = acc & ~i_pwrite & at(i_paddr, CNT_LO_OFS);
  assign wide    = ctrl[BIT_WIDE]; // R10

  // ----------------------------------------
  // APB handshake and read data
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
    else
    begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
      if (i_psel & i_penable & ~o_pready & ~i_pwrite)
      begin
        o_prdata <= 32'h0000_0000;
        if (at(i_paddr, CTRL_OFS))
          o_prdata[7:0] <= {ctrl[7], sysclk_from_timer_osc, ctrl[5:0]}; // R08
        if (at(i_paddr, CNT_LO_OFS))
          o_prdata[7:0] <= count[7:0];
        if (at(i_paddr, CNT_HI_OFS))
          o_prdata[7:0] <= wide ? hi_buf : count[15:8]; // R13
        if (at(i_paddr, INT_STAT_OFS))
          o_prdata[0] <= overflow_flag;
        if (at(i_paddr, INT_MASK_OFS))
          o_prdata[0] <= ovf_mask;
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      ctrl <= CTRL_RST; // R15
    else if (wr_ctrl)
      ctrl <= i_pwdata[7:0] & CTRL_WR_MASK;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      sysclk_from_timer_osc <= 1'b0; // R15
    else
      sysclk_from_timer_osc <= i_sysclk_from_timer_osc; // R08
  end

  // ----------------------------------------
  // Pin and oscillator control
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      o_osc_run         <= 1'b0;
      o_pin_force_input <= 2'b00;
      o_port_read_zero  <= 1'b0;
    end
    else
    begin
      o_osc_run         <= ctrl[BIT_OSC]; // R07
      o_pin_force_input <= {2{ctrl[BIT_ON]}}; // R09
      o_port_read_zero  <= ctrl[BIT_ON]; // R09
    end
  end

  // ----------------------------------------
  // Input synchronisers and edge detect
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      sel_d  <= 1'b0;
    end
    else
    begin
      ext_s1 <= i_ext_count_pin;
      ext_s2 <= ext_s1;
      osc_s1 <= i_osc_input_pin;
      osc_s2 <= osc_s1;
      sel_d  <= sel_lvl;
    end
  end

  assign sel_lvl  = ctrl[BIT_OSC] ? osc_s2 : ext_s2; // R04
  assign ext_edge = sel_lvl & ~sel_d; // R04

  // ----------------------------------------
  // Instruction cycle tick
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      instr_cnt <= 2'b00;
    else
      instr_cnt <= instr_cnt + 2'b01;
  end

  assign instr_tick = (instr_cnt == INSTR_LAST); // R03

  // ----------------------------------------
  // Mode and source selection
  // ----------------------------------------
  always_comb
  begin
    if (!ctrl[BIT_CS])
      mode = MODE_TIMER; // R05
    else if (ctrl[BIT_SYNC])
      mode = MODE_ASYNC; // R05
    else
      mode = MODE_SYNC; // R02
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      ext_pend <= 1'b0;
    else if (mode != MODE_SYNC || instr_tick)
      ext_pend <= 1'b0;
    else if (ext_edge)
      ext_pend <= 1'b1;
  end

  always_comb
  begin
    src_tick = 1'b0;
    unique case (mode)
      MODE_TIMER: src_tick = instr_tick & ~i_sleep; // R03
      MODE_SYNC:  src_tick = instr_tick & (ext_pend | ext_edge) & ~i_sleep; // R05
      MODE_ASYNC: src_tick = ext_edge; // R19
    endcase
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  assign div_mask = divider_mask(ctrl[BIT_DIV_HI:BIT_DIV_LO]); // R18
  assign cnt_inc  = src_tick & ctrl[BIT_ON] & ((pre_cnt & div_mask) == div_mask); // R06
  assign trig_eff = i_special_event & (mode != MODE_ASYNC); // R17

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      pre_cnt <= PRE_RST;
    else if (wr_lo)
      pre_cnt <= PRE_RST; // R14
    else if (src_tick & ctrl[BIT_ON])
      pre_cnt <= pre_cnt + 3'h1; // R01
  end

  // ----------------------------------------
  // Counter and high byte buffer
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      count <= CNT_RST;
    else if (wr_lo)
      count <= {wide ? hi_buf : count[15:8], i_pwdata[7:0]}; // R12
    else if (wr_hi && !wide)
      count <= {i_pwdata[7:0], count[7:0] + {7'h00, cnt_inc}}; // R10
    else if (trig_eff)
      count <= CNT_RST; // R17
    else if (cnt_inc)
      count <= count + 16'h0001; // R16
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      hi_buf <= BYTE_RST;
    else if (wr_hi && wide)
      hi_buf <= i_pwdata[7:0]; // R13
    else if (rd_lo && wide)
      hi_buf <= count[15:8]; // R11
  end

  // ----------------------------------------
  // Overflow flag, mask and interrupt
  // ----------------------------------------
  assign ovf_set = cnt_inc & (count == CNT_MAX) & ~wr_lo & ~(wr_hi & ~wide) & ~trig_eff; // R16

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      overflow_flag <= 1'b0;
    else
      overflow_flag <= (overflow_flag & ~(wr_stat & i_pwdata[0])) | ovf_set; // R16
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      ovf_mask <= 1'b0;
    else if (wr_mask)
      ovf_mask <= i_pwdata[0];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      o_irq <= 1'b0;
    else
      o_irq <= overflow_flag & ovf_mask; // R16
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_freeze;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (!ctrl[BIT_ON] && !wr_lo && !wr_hi && !trig_eff) |=> (count == $past(count));
  endproperty
  a_freeze: assert property (p_freeze) // R01
    else $error("counter moved while disabled");

  property p_timer_rate;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (cnt_inc && mode == MODE_TIMER) |-> (instr_cnt == INSTR_LAST) ##1 !cnt_inc [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate) // R03
    else $error("timer mode counted faster than instruction rate");

  property p_sleep_hold;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (i_sleep && mode != MODE_ASYNC) |-> !cnt_inc;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) // R19
    else $error("synchronised mode counted during sleep");

  property p_wrap;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (cnt_inc && count == CNT_MAX && !wr && !trig_eff) |=> (count == CNT_RST) && overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) // R16
    else $error("rollover did not wrap or set flag");

  property p_trig;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (trig_eff && !wr) |=> (count == CNT_RST) && (overflow_flag == $past(overflow_flag) || $past(wr_stat));
  endproperty
  a_trig: assert property (p_trig) // R17
    else $error("trigger did not clear counter cleanly");

  property p_trig_prec;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (trig_eff && wr_lo) |=> (count[7:0] == $past(i_pwdata[7:0]));
  endproperty
  a_trig_prec: assert property (p_trig_prec) // R17
    else $error("write lost against trigger");

  property p_buf_rd;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (rd_lo && wide && !wr_hi) |=> (hi_buf == $past(count[15:8]));
  endproperty
  a_buf_rd: assert property (p_buf_rd) // R11
    else $error("low read did not capture high byte");

  property p_buf_wr;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (wr_lo && wide) |=> (count == {$past(hi_buf), $past(i_pwdata[7:0])});
  endproperty
  a_buf_wr: assert property (p_buf_wr) // R12
    else $error("wide low write did not load both bytes");

  property p_pre_clr;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      wr_lo |=> (pre_cnt == PRE_RST);
  endproperty
  a_pre_clr: assert property (p_pre_clr) // R14
    else $error("low write left prescaler count");

  property p_pins;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(ctrl[BIT_ON]) |=> (o_pin_force_input == 2'b11) && o_port_read_zero;
  endproperty
  a_pins: assert property (p_pins) // R09
    else $error("pins not forced to input when enabled");

endmodule
`default_nettype wire

// File: dv/t1c_clk_src.sv
// Partner model: external count clock and low-power crystal
`timescale 1ns/1ps
`default_nettype none
module t1c_clk_src #(
  parameter int EXT_HALF = 8,
  parameter int OSC_HALF = 4
)(
  // Clock and oscillator control
  input  wire logic i_core_clk,
  input  wire logic i_osc_run,
  // Pins
  output logic      o_ext_count_pin,
  output logic      o_osc_input_pin
);
  int ext_cnt;
  int osc_cnt;
  initial
  begin
    ext_cnt = 0;
    osc_cnt = 0;
    o_ext_count_pin = 1'b0;
    o_osc_input_pin = 1'b0;
  end
  // Board clock runs free, sleep too
  always @(posedge i_core_clk)
  begin
    ext_cnt = (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
    if (ext_cnt == 0)
      o_ext_count_pin <= ~o_ext_count_pin;
  end
  // Crystal stands still with amplifier off
  always @(posedge i_core_clk)
  begin
    osc_cnt = (!i_osc_run || osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (i_osc_run && osc_cnt == 0)
      o_osc_input_pin <= ~o_osc_input_pin;
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Testbench for the sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import t1c_pkg::*;
  typedef struct packed {logic [7:0] ctrl; logic sleep; int exp;} t1c_row_s;
  logic        core_clk = 1'b0;
  logic        rst_b, psel, penable, pwrite, sleep, sysclk, sevent;
  logic        pready, pslverr, irq, osc_run, port_zero, ext_pin, osc_pin, err;
  logic [1:0]  force_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  int          miscompares = 0;
  int          tests_run = 0;
  logic [7:0]  offs[5] = '{CTRL_OFS, CNT_LO_OFS, CNT_HI_OFS, INT_STAT_OFS, INT_MASK_OFS};
  t1c_row_s    rows[11] = '{'{8'h01, 0, 80}, '{8'h11, 0, 40}, '{8'h21, 0, 20}, '{8'h31, 0, 10},
                            '{8'h03, 0, 20}, '{8'h07, 0, 20}, '{8'h07, 1, 20}, '{8'h03, 1, 0},
                            '{8'h01, 1, 0}, '{8'h0F, 0, 40}, '{8'h06, 0, 0}};

  always #5 core_clk = ~core_clk;

  t1c_timer t1c_timer_inst (
    .i_core_clk(core_clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_count_pin(ext_pin),
    .i_osc_input_pin(osc_pin), .i_sleep(sleep), .i_sysclk_from_timer_osc(sysclk),
    .i_special_event(sevent), .o_osc_run(osc_run), .o_pin_force_input(force_in),
    .o_port_read_zero(port_zero), .o_irq(irq));

  t1c_clk_src t1c_clk_src_inst (
    .i_core_clk(core_clk), .i_osc_run(osc_run), .o_ext_count_pin(ext_pin),
    .o_osc_input_pin(osc_pin));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      miscompares++;
      close_out();
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rv, exp);
  endtask

  task automatic in_range(input string name, input int lo, input int hi);
    check(name, {31'h0, (rv >= lo && rv <= hi)}, 32'h1);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, sleep, sysclk, sevent, rst_b} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (offs[i]) rc("reset", offs[i], 32'h0);
    foreach (rows[i])
    begin
      wr(CNT_HI_OFS, 32'h0);
      wr(CNT_LO_OFS, 32'h0);
      sleep <= rows[i].sleep;
      wr(CTRL_OFS, {24'h0, rows[i].ctrl});
      repeat (317) @(posedge core_clk);
      check("force", {30'h0, force_in}, {30'h0, {2{rows[i].ctrl[0]}}});
      check("zero", {31'h0, port_zero}, {31'h0, rows[i].ctrl[0]});
      check("osc", {31'h0, osc_run}, {31'h0, rows[i].ctrl[3]});
      wr(CTRL_OFS, 32'h0);
      sleep <= 1'b0;
      apb(1'b0, CNT_LO_OFS, 32'h0);
      in_range("count", rows[i].exp - (rows[i].exp ? 2 : 0), rows[i].exp + (rows[i].exp ? 2 : 0));
    end
    wr(CTRL_OFS, 32'hFFFFFFFF);
    rc("ctrl", CTRL_OFS, 32'hBF);
    wr(CTRL_OFS, 32'h0);
    sysclk <= 1'b1;
    rc("run", CTRL_OFS, 32'h40);
    sysclk <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    // Overflow, mask and clear
    wr(CNT_HI_OFS, 32'hFF);
    wr(CNT_LO_OFS, 32'hFE);
    wr(CTRL_OFS, 32'h01);
    repeat (30) @(posedge core_clk);
    check("irq", {31'h0, irq}, 32'h0);
    rc("flag", INT_STAT_OFS, 32'h1);
    apb(1'b0, CNT_HI_OFS, 32'h0);
    check("wrap", rv, 32'h0);
    wr(INT_MASK_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    check("irq", {31'h0, irq}, 32'h1);
    wr(INT_STAT_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    check("irq", {31'h0, irq}, 32'h0);
    // Compare trigger, then trigger against a write
    repeat (100) @(posedge core_clk);
    sevent <= 1'b1;
    @(posedge core_clk);
    sevent <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    apb(1'b0, CNT_LO_OFS, 32'h0);
    in_range("trig", 0, 2);
    rc("flag", INT_STAT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h01);
    sevent <= 1'b1;
    wr(CNT_LO_OFS, 32'h40);
    sevent <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    apb(1'b0, CNT_LO_OFS, 32'h0);
    in_range("wins", 32'h40, 32'h42);
    // Buffered sixteen-bit access
    wr(CTRL_OFS, 32'h80);
    wr(CNT_HI_OFS, 32'h12);
    wr(CNT_LO_OFS, 32'h34);
    wr(CTRL_OFS, 32'h0);
    rc("hi", CNT_HI_OFS, 32'h12);
    wr(CNT_HI_OFS, 32'h56);
    rc("hi", CNT_HI_OFS, 32'h56);
    wr(CTRL_OFS, 32'h80);
    wr(CNT_HI_OFS, 32'h99);
    rc("buf", CNT_HI_OFS, 32'h99);
    wr(CTRL_OFS, 32'h0);
    rc("hi", CNT_HI_OFS, 32'h56);
    wr(CTRL_OFS, 32'h80);
    rc("lo", CNT_LO_OFS, 32'h34);
    rc("buf", CNT_HI_OFS, 32'h56);
    // Prescaler kept by high writes, cleared by low writes
    wr(CTRL_OFS, 32'h31);
    repeat (10)
    begin
      repeat (20) @(posedge core_clk);
      wr(CNT_HI_OFS, 32'h0);
    end
    wr(CTRL_OFS, 32'h0);
    apb(1'b0, CNT_LO_OFS, 32'h0);
    in_range("keep", 32'h3B, 32'h3E);
    wr(CTRL_OFS, 32'h31);
    repeat (8)
    begin
      repeat (20) @(posedge core_clk);
      wr(CNT_LO_OFS, 32'h0);
    end
    repeat (20) @(posedge core_clk);
    wr(CTRL_OFS, 32'h0);
    rc("clear", CNT_LO_OFS, 32'h0);
    // Reset in mid-run clears every register and pin control
    wr(INT_MASK_OFS, 32'h1);
    wr(CTRL_OFS, 32'h8F);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    check("force", {30'h0, force_in}, 32'h0);
    check("zero", {31'h0, port_zero}, 32'h0);
    check("osc", {31'h0, osc_run}, 32'h0);
    foreach (offs[i]) rc("reset", offs[i], 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
